// *** hdl/serial_link_sync_init_control.sv ***
`timescale 1ns/1ps
// How it works
// - single-ended sync pin is active-low link start, 8B/10B, select 0
// - in 64B/66B every sync input is ignored, no handshake
// - selected sync low in 8B/10B starts code group synchronization
// - sync released high after sync starts lane alignment sequence
// - sysref aligns internal timing for deterministic latency
// - sysref receiver off: powered down and input ignored
// - timestamp receiver off at 0: powered down, input ignored
// - timestamp pair selectable as alternate active-low sync source
module serial_link_sync_init_control #(
  parameter int LANES = sync_init_pkg::LANES,
  parameter int ILAS_CYCLES = sync_init_pkg::ILAS_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // configuration
  input wire logic link_en_i,
  input wire logic enc_64b66b_i,
  input wire logic [1:0] sync_sel_i,
  input wire logic [LANES-1:0] lane_active_i,
  input wire logic sysref_receiver_on_i,
  input wire logic timestamp_receiver_on_i,
  // pins, already resolved to logic levels
  input wire logic single_ended_sync_pin_i,
  input wire logic alt_diff_sync_pin_i,
  input wire logic timestamp_pair_i,
  input wire logic sysref_i,
  // link outputs
  output logic [LANES-1:0] lane_send_cgs_o,
  output logic [LANES-1:0] lane_send_ilas_o,
  output logic [LANES-1:0] lane_send_data_o,
  output logic [1:0] phase_o,
  output logic lmfc_align_o,
  output logic timestamp_o,
  output logic sysref_rx_pd_o,
  output logic timestamp_rx_pd_o
);

  typedef enum logic [1:0] {
    ST_IDLE = sync_init_pkg::PHASE_IDLE,
    ST_CGS = sync_init_pkg::PHASE_CGS,
    ST_ILAS = sync_init_pkg::PHASE_ILAS,
    ST_DATA = sync_init_pkg::PHASE_DATA
  } link_state_t;

  localparam int CW = $clog2(ILAS_CYCLES + 1);
  localparam logic [CW-1:0] ILAS_LAST = CW'(ILAS_CYCLES - 1);

  link_state_t state_reg;
  link_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic sync_n;
  logic sref_reg;
  logic sref_next;
  logic align_reg;
  logic align_next;
  logic ts_reg;
  logic ts_next;
  logic [LANES-1:0] cgs_reg;
  logic [LANES-1:0] cgs_next;
  logic [LANES-1:0] ilas_reg;
  logic [LANES-1:0] ilas_next;
  logic [LANES-1:0] data_reg;
  logic [LANES-1:0] data_next;
  logic cgs_on;
  logic ilas_on;
  logic data_on;

  // one decode shared by the three lane groups
  function automatic logic in_phase(
    input link_state_t s,
    input link_state_t want
  );
    in_phase = (s == want);
  endfunction : in_phase

  // sync mux; a powered-down timestamp receiver reads as released (high)
  always_comb
  begin
    unique case (sync_sel_i)
      sync_init_pkg::SYNC_SRC_SE: sync_n = single_ended_sync_pin_i;
      sync_init_pkg::SYNC_SRC_TS:
        sync_n = timestamp_receiver_on_i ? timestamp_pair_i : 1'b1;
      sync_init_pkg::SYNC_SRC_ALT: sync_n = alt_diff_sync_pin_i;
      default: sync_n = 1'b1;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!link_en_i)
    begin
      state_next = ST_IDLE;
    end
    else if (enc_64b66b_i)
    begin
      // no handshake at all in this encoding
      state_next = ST_DATA;
    end
    else if (!sync_n)
    begin
      // resync request from any phase restarts sync characters
      state_next = ST_CGS;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE: state_next = ST_IDLE;
        ST_CGS:
        begin
          state_next = ST_ILAS;
          cnt_next = '0;
        end
        ST_ILAS:
        begin
          cnt_next = cnt_reg + CW'(1);
          if (cnt_reg == ILAS_LAST)
            state_next = ST_DATA;
        end
        ST_DATA: state_next = ST_DATA;
      endcase
    end
  end

  // sysref edge marks the multiframe boundary; ignored when receiver is off
  always_comb
  begin
    sref_next = sysref_receiver_on_i & sysref_i;
    align_next = sysref_receiver_on_i & sysref_i & ~sref_reg;
  end

  // timestamp blanked while the pair carries the sync request
  always_comb
  begin
    ts_next = timestamp_receiver_on_i & timestamp_pair_i
      & (sync_sel_i != sync_init_pkg::SYNC_SRC_TS);
  end

  // flags from the next state so lanes switch together with phase_o
  always_comb
  begin
    cgs_on = in_phase(state_next, ST_CGS);
    ilas_on = in_phase(state_next, ST_ILAS);
    data_on = in_phase(state_next, ST_DATA);
  end

  // an inactive lane stays silent in every phase
  for (genvar lane = 0; lane < LANES; lane++)
  begin : g_lane
    assign cgs_next[lane] = cgs_on & lane_active_i[lane];
    assign ilas_next[lane] = ilas_on & lane_active_i[lane];
    assign data_next[lane] = data_on & lane_active_i[lane];
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sref_reg <= 1'b0;
      align_reg <= 1'b0;
    end
    else
    begin
      sref_reg <= sref_next;
      align_reg <= align_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ts_reg <= 1'b0;
    end
    else
    begin
      ts_reg <= ts_next;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cgs_reg <= '0;
      ilas_reg <= '0;
      data_reg <= '0;
    end
    else
    begin
      cgs_reg <= cgs_next;
      ilas_reg <= ilas_next;
      data_reg <= data_next;
    end
  end

  assign lane_send_cgs_o = cgs_reg;
  assign lane_send_ilas_o = ilas_reg;
  assign lane_send_data_o = data_reg;
  assign phase_o = state_reg;
  assign lmfc_align_o = align_reg;
  assign timestamp_o = ts_reg;
  // power-down straight from the enables, no pipeline needed
  assign sysref_rx_pd_o = ~sysref_receiver_on_i;
  assign timestamp_rx_pd_o = ~timestamp_receiver_on_i;

endmodule : serial_link_sync_init_control

// *** hdl/sync_init_pkg.sv ***
package sync_init_pkg;
  // sync source select encodings
  localparam logic [1:0] SYNC_SRC_SE = 2'h0;
  localparam logic [1:0] SYNC_SRC_TS = 2'h1;
  localparam logic [1:0] SYNC_SRC_ALT = 2'h2;
  // link phase codes seen on the status output
  localparam logic [1:0] PHASE_IDLE = 2'h0;
  localparam logic [1:0] PHASE_CGS = 2'h1;
  localparam logic [1:0] PHASE_ILAS = 2'h3;
  localparam logic [1:0] PHASE_DATA = 2'h2;
  // default lane alignment sequence length in clock cycles
  localparam int ILAS_CYCLES = 64;
  localparam int LANES = 8;
endpackage : sync_init_pkg

// *** dv/sync_rx_model.sv ***
`timescale 1ns/1ps
module sync_rx_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [1:0] sel_i,
  output logic se_o = 1'b0,
  output logic alt_o = 1'b1,
  output logic ts_o = 1'b0
);
  // only the chosen line carries the request; a spare se pin is tied low
  // off sync duty the pair carries req as a plain stamp level
  always_ff @(posedge clk_i)
  begin
    se_o <= sel_i == 2'h0 && !req_i;
    alt_o <= sel_i != 2'h2 || !req_i;
    ts_o <= sel_i == 2'h1 ? !req_i : req_i;
  end
endmodule : sync_rx_model

// *** dv/serial_link_sync_init_control_properties.sv ***
`timescale 1ns/1ps
module serial_link_sync_init_control_properties (
  input wire logic clk_i, rst_n_i, link_en_i, enc_64b66b_i,
  input wire logic [1:0] sync_sel_i, phase_o,
  input wire logic single_ended_sync_pin_i, alt_diff_sync_pin_i,
  input wire logic timestamp_pair_i, timestamp_receiver_on_i, timestamp_o,
  input wire logic sysref_i, sysref_receiver_on_i, lmfc_align_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire g = link_en_i && !enc_64b66b_i;
  wire g0 = g && sync_sel_i == 2'h0;
  wire n0 = !single_ended_sync_pin_i;
  wire t1 = g && sync_sel_i == 2'h1 && timestamp_receiver_on_i;
  wire a2 = g && sync_sel_i == 2'h2 && !alt_diff_sync_pin_i;
  property p_se; g0 && n0 |=> phase_o == 2'h1; endproperty
  a_se: assert property (p_se) else $error("no cgs");
  property p_ts; t1 && !timestamp_pair_i |=> phase_o == 2'h1; endproperty
  a_ts: assert property (p_ts) else $error("no cgs");
  property p_alt; a2 |=> phase_o == 2'h1; endproperty
  a_alt: assert property (p_alt) else $error("no cgs");
  property p_rel; phase_o == 2'h1 && g0 && !n0 |=> phase_o == 2'h3; endproperty
  a_rel: assert property (p_rel) else $error("no ilas");
  property p_64; link_en_i && enc_64b66b_i |=> phase_o == 2'h2; endproperty
  a_64: assert property (p_64) else $error("no data");
  property p_sr; sysref_receiver_on_i && $rose(sysref_i) |-> ##1 lmfc_align_o;
  endproperty
  a_sr: assert property (p_sr) else $error("no align");
  property p_off; !sysref_receiver_on_i [*3] |-> !lmfc_align_o; endproperty
  a_off: assert property (p_off) else $error("align");
  property p_tso; !timestamp_receiver_on_i |=> !timestamp_o; endproperty
  a_tso: assert property (p_tso) else $error("stamp");
  c_ilas: cover property (phase_o == 2'h3);
  c_data: cover property (phase_o == 2'h2);
  c_align: cover property (lmfc_align_o);
endmodule : serial_link_sync_init_control_properties
bind serial_link_sync_init_control serial_link_sync_init_control_properties
  serial_link_sync_init_control_properties_inst (.*);

// *** dv/serial_link_sync_init_control_tb.sv ***
`timescale 1ns/1ps
module serial_link_sync_init_control_tb;
  logic clk_i = 1'b0, rst_n_i = 1'b0, link_en_i = 1'b0, enc_64b66b_i = 1'b0;
  logic sysref_receiver_on_i = 1'b0, timestamp_receiver_on_i = 1'b1;
  logic sysref_i = 1'b0, req = 1'b0;
  logic [1:0] sync_sel_i = 2'h0, phase_o;
  logic [7:0] lane_active_i = 8'hA5, lane_send_cgs_o, lane_send_ilas_o;
  logic [7:0] lane_send_data_o;
  logic single_ended_sync_pin_i, alt_diff_sync_pin_i, timestamp_pair_i;
  logic lmfc_align_o, timestamp_o, sysref_rx_pd_o, timestamp_rx_pd_o;
  int failures = 0, total_checks = 0, n;
  always #2.5 clk_i = ~clk_i;
  sync_rx_model sync_rx_model_inst (.clk_i, .req_i(req), .sel_i(sync_sel_i),
    .se_o(single_ended_sync_pin_i), .alt_o(alt_diff_sync_pin_i),
    .ts_o(timestamp_pair_i));
  // short alignment sequence keeps the run brief
  serial_link_sync_init_control #(.ILAS_CYCLES(4))
    serial_link_sync_init_control_inst (.*);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : step
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  task automatic link_up(input logic [1:0] s);
    @(posedge clk_i);
    sync_sel_i <= s;
    req <= 1'b1;
    link_en_i <= 1'b1;
    step(4);
    chk(8'(phase_o), 8'h01);
    chk(lane_send_cgs_o, 8'hA5);
    chk(lane_send_ilas_o, 8'h00);
    chk(8'(timestamp_o), 8'(s != 2'h1));
    @(posedge clk_i);
    req <= 1'b0;
    n = 0;
    for (int i = 0; i < 20 && phase_o !== 2'h2; i++)
    begin
      step(1);
      n += int'(phase_o === 2'h3 && lane_send_ilas_o === 8'hA5);
    end
    chk(8'(n), 8'h04);
    chk(lane_send_data_o, 8'hA5);
    if (phase_o !== 2'h2)
    begin
      failures++;
      complete_run();
    end
    else
      $display("link_up %0d done", s);
  endtask : link_up
  task automatic ts_off();
    @(posedge clk_i);
    link_en_i <= 1'b0;
    timestamp_receiver_on_i <= 1'b0;
    sync_sel_i <= 2'h1;
    req <= 1'b1;
    repeat (2) @(posedge clk_i);
    link_en_i <= 1'b1;
    step(4);
    chk(8'(phase_o), 8'h00);
    chk(8'(timestamp_o), 8'h00);
    chk(8'(timestamp_rx_pd_o), 8'h01);
    @(posedge clk_i);
    enc_64b66b_i <= 1'b1;
    timestamp_receiver_on_i <= 1'b1;
    step(3);
    chk(8'(phase_o), 8'h02);
    chk(8'(timestamp_rx_pd_o), 8'h00);
    $display("ts_off and 64b66b done");
  endtask : ts_off
  task automatic sr(input logic on, input int exp);
    @(posedge clk_i);
    sysref_receiver_on_i <= on;
    sysref_i <= 1'b1;
    n = 0;
    repeat (6)
    begin
      step(1);
      n += int'(lmfc_align_o === 1'b1);
    end
    chk(8'(n), 8'(exp));
    chk(8'(sysref_rx_pd_o), 8'(!on));
    @(posedge clk_i);
    sysref_i <= 1'b0;
    step(2);
    $display("sysref %0d done", on);
  endtask : sr
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    link_up(2'h0);
    link_up(2'h1);
    link_up(2'h2);
    ts_off();
    sr(1'b1, 1);
    sr(1'b0, 0);
    complete_run();
  end
endmodule : serial_link_sync_init_control_tb
